/* File: hdl/rxfc_pkg.sv */
// Constants and types for the receive frame check and lane marker block
package rxfc_pkg;

    // ======================================================================
    // Register map, byte addresses
    localparam logic [11:0] RXFC_ADDR_CTRL    = 12'h000;
    localparam logic [11:0] RXFC_ADDR_MAXLEN  = 12'h004;
    localparam logic [11:0] RXFC_ADDR_MINLEN  = 12'h008;
    localparam logic [11:0] RXFC_ADDR_SPACING = 12'h00C;
    localparam logic [11:0] RXFC_ADDR_STATUS  = 12'h010;
    localparam logic [11:0] RXFC_ADDR_MASK    = 12'h014;
    localparam logic [11:0] RXFC_ADDR_LANE    = 12'h018;
    localparam logic [3:0]  RXFC_MARKER_PAGE  = 4'h1;

    // ======================================================================
    // Field positions and reset values
    localparam int          RXFC_CTRL_IGNORE  = 0;
    localparam int          RXFC_IRQ_FCS      = 0;
    localparam int          RXFC_IRQ_OVER     = 1;
    localparam int          RXFC_IRQ_UNDER    = 2;
    localparam int          RXFC_IRQ_RUNT     = 3;
    localparam int          RXFC_IRQ_LOST     = 4;
    localparam int          RXFC_IRQ_W        = 5;
    localparam logic [14:0] RXFC_MAXLEN_RST   = 15'h2580;
    localparam logic [7:0]  RXFC_MINLEN_RST   = 8'h40;
    localparam logic [15:0] RXFC_SPACING_RST  = 16'h3FFF;
    localparam logic [6:0]  RXFC_BEAT_BYTES   = 7'h40;
    localparam int          RXFC_LANES        = 20;

    // ======================================================================
    // Standard lane marker patterns, lane 19 first
    localparam logic [19:0][63:0] RXFC_MARKER_RST = '{
        64'hC0F0E5003F0F1A00, 64'h5F662A00A099D500, 64'hADD6B70052294800,
        64'hC4314C003BCEB300, 64'h3536CD00CAC93200, 64'h83C7CA007C383500,
        64'h1AF8BD00E5074200, 64'h5CB9B200A3464D00, 64'hB9915500466EAA00,
        64'hFD6C990002936600, 64'h68C9FB0097360400, 64'hA02476005FDB8900,
        64'h7B45660084BA9900, 64'h9A4A260065B5D900, 64'hDD14C20022EB3D00,
        64'hF50709000AF8F600, 64'h4D957B00B26A8400, 64'h594BE800A6B41700,
        64'h9D718E00628E7100, 64'hC16821003E97DE00};

    // ======================================================================
    // State of the top module
    typedef struct packed {
        logic                 ignore_fcs;
        logic [14:0]          max_len;
        logic [7:0]           min_len;
        logic [15:0]          spacing;
        logic [RXFC_IRQ_W-1:0] irq_stat;
        logic [RXFC_IRQ_W-1:0] irq_mask;
        logic [31:0]          rd_word;
        logic [15:0]          len;
        logic                 dropping;
        logic                 out_v;
        logic [511:0]         out_data;
        logic                 out_sop;
        logic                 out_eop;
        logic                 out_err;
        logic [5:0]           out_mty;
        logic                 st_good;
        logic                 st_bad;
        logic                 st_over;
        logic                 st_under;
        logic                 st_runt;
        logic [16:0]          mk_cnt;
        logic                 locked;
        logic [4:0]           lane;
        logic                 mk_touched;
    } rxfc_state_type;

    // State of the marker store
    typedef struct packed {
        logic [19:0][63:0]    pat;
        logic [31:0]          rd;
    } rxfc_store_type;

endpackage : rxfc_pkg

/* File: hdl/rxfc_marker_if.sv */
// Marker pattern access between the top, the store and the matcher
`timescale 1ns/1ps
interface rxfc_marker_if;
    logic              wr_en;
    logic [4:0]        wr_lane;
    logic              wr_hi;
    logic [31:0]       wr_data;
    logic [4:0]        rd_lane;
    logic              rd_hi;
    logic [31:0]       rd_data;
    logic [19:0][63:0] pattern;

    modport ctl   (output wr_en, wr_lane, wr_hi, wr_data, rd_lane, rd_hi,
                   input rd_data, pattern);
    modport store (input wr_en, wr_lane, wr_hi, wr_data, rd_lane, rd_hi,
                   output rd_data, pattern);
    modport match (input pattern);
endinterface : rxfc_marker_if

/* File: hdl/rxfc_marker_store.sv */
// Twenty 64-bit lane marker patterns with a registered read port
`timescale 1ns/1ps
module rxfc_marker_store
(
    input  wire logic   clk_sys,
    input  wire logic   reset,
    rxfc_marker_if.store mif
);
    import rxfc_pkg::*;

    rxfc_store_type q;
    rxfc_store_type d;

    // Half-word writes and read capture
    always_comb
    begin
        d = q;
        if (mif.wr_en && mif.wr_lane < 5'(RXFC_LANES))
        begin
            if (mif.wr_hi)
                d.pat[mif.wr_lane][63:32] = mif.wr_data;
            else
                d.pat[mif.wr_lane][31:0] = mif.wr_data;
        end
        d.rd = 32'h0;
        if (mif.rd_lane < 5'(RXFC_LANES))
            d.rd = mif.rd_hi ? q.pat[mif.rd_lane][63:32]
                             : q.pat[mif.rd_lane][31:0];
    end

    // State register, standard patterns at reset
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            q.pat <= RXFC_MARKER_RST;
            q.rd  <= 32'h0;
        end
        else
            q <= d;
    end

    assign mif.rd_data = q.rd;
    assign mif.pattern = q.pat;
endmodule : rxfc_marker_store

/* File: hdl/rxfc_lane_match.sv */
// Compares one block against all marker patterns
`timescale 1ns/1ps
module rxfc_lane_match
(
    rxfc_marker_if.match    mif,
    input  wire logic [63:0] block,
    output logic             hit,
    output logic [4:0]       id
);
    import rxfc_pkg::*;

    // Lowest matching lane wins
    always_comb
    begin
        hit = 1'b0;
        id  = 5'h00;
        for (int i = 0; i < RXFC_LANES; i++)
        begin
            if (!hit && block == mif.pattern[i])
            begin
                hit = 1'b1;
                id  = 5'(i);
            end
        end
    end
endmodule : rxfc_lane_match

/* File: hdl/rxfc_top.sv */
// Receive frame checks, lane marker tracking and APB registers
`timescale 1ns/1ps
module rxfc_top
(
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic              pready,
    output logic [31:0]       prdata,
    output logic              pslverr,
    input  wire logic         rx_in_valid,
    input  wire logic [511:0] rx_in_data,
    input  wire logic         rx_in_sop,
    input  wire logic         rx_in_eop,
    input  wire logic [5:0]   rx_in_mty,
    input  wire logic         rx_in_fcs_bad,
    output logic              rx_beat_valid_out,
    output logic [511:0]      rx_data_out,
    output logic              rx_sop_out,
    output logic              rx_eop_out,
    output logic              rx_err_out,
    output logic [5:0]        rx_mty_out,
    output logic              stat_rx_good,
    output logic              stat_rx_bad_fcs,
    output logic              stat_rx_oversize,
    output logic              stat_rx_undersize,
    output logic              stat_rx_runt,
    input  wire logic         pcs_valid,
    input  wire logic [63:0]  pcs_word,
    output logic              lane_locked,
    output logic [4:0]        lane_id,
    output logic              irq
);
    import rxfc_pkg::*;

    rxfc_state_type q;
    rxfc_state_type d;
    rxfc_marker_if  mif ();
    logic           mk_hit;
    logic [4:0]     mk_id;
    logic           bus_wr;
    logic           bus_rd;
    logic           in_marker;
    logic           mapped;
    logic [6:0]     beat_bytes;
    logic [15:0]    base_len;
    logic [15:0]    new_len;
    logic [15:0]    max16;
    logic [15:0]    keep;
    logic           over;
    logic           under;
    logic [RXFC_IRQ_W-1:0] events;

    // ======================================================================
    // Submodules
    rxfc_marker_store u_store
    (
        .clk_sys (clk_sys),
        .reset   (reset),
        .mif     (mif)
    );

    rxfc_lane_match u_match
    (
        .mif   (mif),
        .block (pcs_word),
        .hit   (mk_hit),
        .id    (mk_id)
    );

    // ======================================================================
    // APB decode
    assign bus_wr    = psel && penable && pwrite;
    assign bus_rd    = psel && penable && !pwrite;
    assign in_marker = paddr[11:8] == RXFC_MARKER_PAGE
                       && paddr[7:3] < 5'(RXFC_LANES) && paddr[1:0] == 2'b00;
    assign mapped    = in_marker || paddr == RXFC_ADDR_CTRL
                       || paddr == RXFC_ADDR_MAXLEN
                       || paddr == RXFC_ADDR_MINLEN
                       || paddr == RXFC_ADDR_SPACING
                       || paddr == RXFC_ADDR_STATUS
                       || paddr == RXFC_ADDR_MASK
                       || paddr == RXFC_ADDR_LANE;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign prdata    = in_marker ? mif.rd_data : q.rd_word;

    // Marker store port
    assign mif.wr_en   = bus_wr && in_marker;
    assign mif.wr_lane = paddr[7:3];
    assign mif.wr_hi   = paddr[2];
    assign mif.wr_data = pwdata;
    assign mif.rd_lane = paddr[7:3];
    assign mif.rd_hi   = paddr[2];

    // ======================================================================
    // Length arithmetic of the incoming beat
    always_comb
    begin
        beat_bytes = rx_in_eop ? RXFC_BEAT_BYTES - {1'b0, rx_in_mty}
                               : RXFC_BEAT_BYTES;
        base_len   = rx_in_sop ? 16'h0000 : q.len;
        new_len    = base_len + {9'h000, beat_bytes};
        max16      = {1'b0, q.max_len};
        // Reaching the limit without an end means the packet will exceed it
        over       = new_len > max16 || (new_len == max16 && !rx_in_eop);
        keep       = max16 - base_len;
        under      = new_len < {8'h00, q.min_len};
    end

    // ======================================================================
    // Next state
    always_comb
    begin
        d          = q;
        d.out_v    = 1'b0;
        d.st_good  = 1'b0;
        d.st_bad   = 1'b0;
        d.st_over  = 1'b0;
        d.st_under = 1'b0;
        d.st_runt  = 1'b0;

        // Register writes
        if (bus_wr)
        begin
            case (paddr)
                RXFC_ADDR_CTRL:    d.ignore_fcs = pwdata[RXFC_CTRL_IGNORE];
                RXFC_ADDR_MAXLEN:  d.max_len = pwdata[14:0];
                RXFC_ADDR_MINLEN:  d.min_len = pwdata[7:0];
                RXFC_ADDR_SPACING: d.spacing = pwdata[15:0];
                RXFC_ADDR_MASK:    d.irq_mask = pwdata[RXFC_IRQ_W-1:0];
                default:           d.mk_touched = q.mk_touched || in_marker;
            endcase
        end

        // Read word captured in the setup cycle
        if (psel && !penable)
        begin
            case (paddr)
                RXFC_ADDR_CTRL:    d.rd_word = {31'h0, q.ignore_fcs};
                RXFC_ADDR_MAXLEN:  d.rd_word = {17'h0, q.max_len};
                RXFC_ADDR_MINLEN:  d.rd_word = {24'h0, q.min_len};
                RXFC_ADDR_SPACING: d.rd_word = {16'h0, q.spacing};
                RXFC_ADDR_STATUS:  d.rd_word = {27'h0, q.irq_stat};
                RXFC_ADDR_MASK:    d.rd_word = {27'h0, q.irq_mask};
                RXFC_ADDR_LANE:    d.rd_word = {26'h0, q.locked, q.lane};
                default:           d.rd_word = 32'h0;
            endcase
        end

        // Packet path
        if (rx_in_valid)
        begin
            if (rx_in_sop && rx_in_eop && rx_in_mty != 6'h00)
            begin
                // Under 64 bytes: swallowed whole
                d.st_runt  = 1'b1;
                d.dropping = 1'b0;
            end
            else if (q.dropping && !rx_in_sop)
            begin
                // Tail of a truncated packet
                d.dropping = !rx_in_eop;
            end
            else
            begin
                d.out_v    = 1'b1;
                d.out_data = rx_in_data;
                d.out_sop  = rx_in_sop;
                d.out_eop  = rx_in_eop;
                d.out_mty  = rx_in_eop ? rx_in_mty : 6'h00;
                d.out_err  = 1'b0;
                d.len      = new_len;
                d.dropping = 1'b0;
                if (over)
                begin
                    // Cut at the limit and close with an error
                    d.out_eop  = 1'b1;
                    d.out_err  = 1'b1;
                    d.out_mty  = 6'(RXFC_BEAT_BYTES - keep[6:0]);
                    d.len      = max16;
                    d.st_over  = 1'b1;
                    d.dropping = !rx_in_eop;
                end
                else if (rx_in_eop)
                begin
                    d.st_under = under;
                    d.st_bad   = rx_in_fcs_bad;
                    // Checksum error shown only when not ignored
                    d.out_err  = under || (rx_in_fcs_bad
                                 && !q.ignore_fcs);
                    d.st_good  = !under
                                 && (q.ignore_fcs || !rx_in_fcs_bad);
                end
            end
        end

        // Lane marker tracking
        if (pcs_valid)
        begin
            if (!q.locked)
            begin
                if (mk_hit)
                begin
                    d.locked = 1'b1;
                    d.lane   = mk_id;
                    d.mk_cnt = 17'h00000;
                end
            end
            else if (q.mk_cnt == {1'b0, q.spacing} + 17'h00001)
            begin
                if (mk_hit && mk_id == q.lane)
                    d.mk_cnt = 17'h00000;
                else
                    d.locked = 1'b0;
            end
            else
                d.mk_cnt = q.mk_cnt + 17'h00001;
        end

        // Sticky events, a read clears, a new event wins
        events = '0;
        events[RXFC_IRQ_FCS]   = d.st_bad;
        events[RXFC_IRQ_OVER]  = d.st_over;
        events[RXFC_IRQ_UNDER] = d.st_under;
        events[RXFC_IRQ_RUNT]  = d.st_runt;
        events[RXFC_IRQ_LOST]  = q.locked && !d.locked;
        d.irq_stat = ((bus_rd && paddr == RXFC_ADDR_STATUS) ? '0 : q.irq_stat)
                     | events;
    end

    // ======================================================================
    // State register
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            q            <= '0;
            q.max_len    <= RXFC_MAXLEN_RST;
            q.min_len    <= RXFC_MINLEN_RST;
            q.spacing    <= RXFC_SPACING_RST;
        end
        else
            q <= d;
    end

    // Outputs
    assign rx_beat_valid_out = q.out_v;
    assign rx_data_out       = q.out_data;
    assign rx_sop_out        = q.out_sop;
    assign rx_eop_out        = q.out_eop;
    assign rx_err_out        = q.out_err;
    assign rx_mty_out        = q.out_mty;
    assign stat_rx_good      = q.st_good;
    assign stat_rx_bad_fcs   = q.st_bad;
    assign stat_rx_oversize  = q.st_over;
    assign stat_rx_undersize = q.st_under;
    assign stat_rx_runt      = q.st_runt;
    assign lane_locked       = q.locked;
    assign lane_id           = q.lane;
    assign irq               = |(q.irq_stat & q.irq_mask);

    // ======================================================================
    // Checks
    property p_ignore_no_err;
        @(posedge clk_sys) disable iff (reset)
        rx_beat_valid_out && rx_eop_out && stat_rx_bad_fcs && q.ignore_fcs
        && !stat_rx_undersize |-> !rx_err_out;
    endproperty
    a_ignore_no_err: assert property (p_ignore_no_err)
        else $error("bad checksum flagged while ignored");

    property p_bad_fcs_err;
        @(posedge clk_sys) disable iff (reset)
        rx_in_valid && rx_in_eop && rx_in_fcs_bad && !q.ignore_fcs
        && !(rx_in_sop && rx_in_mty != 6'h00) && !(q.dropping && !rx_in_sop)
        |=> rx_beat_valid_out && rx_eop_out && rx_err_out;
    endproperty
    a_bad_fcs_err: assert property (p_bad_fcs_err)
        else $error("bad checksum frame ended without error");

    property p_ignore_good;
        @(posedge clk_sys) disable iff (reset)
        stat_rx_bad_fcs && q.ignore_fcs && !stat_rx_undersize
        |-> stat_rx_good && !rx_err_out;
    endproperty
    a_ignore_good: assert property (p_ignore_good)
        else $error("ignored checksum error not counted good");

    property p_trunc;
        @(posedge clk_sys) disable iff (reset)
        stat_rx_oversize |-> rx_beat_valid_out && rx_eop_out && rx_err_out
        && q.len == {1'b0, q.max_len};
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("oversize packet not cut at the limit");

    property p_runt_drop;
        @(posedge clk_sys) disable iff (reset)
        rx_in_valid && rx_in_sop && rx_in_eop && rx_in_mty != 6'h00
        |=> !rx_beat_valid_out && stat_rx_runt;
    endproperty
    a_runt_drop: assert property (p_runt_drop)
        else $error("short packet delivered");

    property p_under;
        @(posedge clk_sys) disable iff (reset)
        stat_rx_undersize |-> rx_beat_valid_out && rx_eop_out && rx_err_out
        && !stat_rx_good;
    endproperty
    a_under: assert property (p_under)
        else $error("undersize packet ended without error");

    property p_marker_miss;
        @(posedge clk_sys) disable iff (reset)
        pcs_valid && q.locked && q.mk_cnt == {1'b0, q.spacing} + 17'h00001
        && !mk_hit |=> !lane_locked && q.irq_stat[RXFC_IRQ_LOST];
    endproperty
    a_marker_miss: assert property (p_marker_miss)
        else $error("missing marker did not drop lock");

    property p_store_write;
        @(posedge clk_sys) disable iff (reset)
        mif.wr_en && mif.wr_hi
        |=> mif.pattern[$past(mif.wr_lane)][63:32] == $past(mif.wr_data);
    endproperty
    a_store_write: assert property (p_store_write)
        else $error("marker pattern write lost");

    property p_default_pat;
        @(posedge clk_sys) disable iff (reset)
        !q.mk_touched |-> mif.pattern == RXFC_MARKER_RST;
    endproperty
    a_default_pat: assert property (p_default_pat)
        else $error("marker pattern differs from reset value");

    property p_lock;
        @(posedge clk_sys) disable iff (reset)
        pcs_valid && !q.locked && mk_hit
        |=> lane_locked && lane_id == $past(mk_id);
    endproperty
    a_lock: assert property (p_lock)
        else $error("marker match did not set lane");

endmodule : rxfc_top

/* File: bench/rxfc_sink.sv */
// Model of the user logic on the receive packet bus
`timescale 1ns/1ps
module rxfc_sink
(
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       clr,
    input  wire logic       v,
    input  wire logic       eop,
    input  wire logic       sop,
    input  wire logic [31:0] data_lo,
    input  wire logic       err,
    input  wire logic [5:0] mty,
    input  wire logic [4:0] st,
    output logic            last_err,
    output logic [5:0]      last_mty,
    output logic [4:0]      flags,
    output logic [7:0]      beats,
    output logic [7:0]      sops,
    output logic [31:0]     last_word
);
    // ==========
    // Capture
    // Beat count, end beat fields, sticky stat pulses
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            {last_err, last_mty, flags, beats, sops, last_word} <= '0;
        else if (clr)
            {last_err, last_mty, flags, beats, sops, last_word} <= '0;
        else
        begin
            flags <= flags | st;
            if (v)
                beats <= beats + 8'h01;
            if (v && sop)
                sops <= sops + 8'h01;
            if (v && eop)
            begin
                last_err <= err;
                last_mty <= mty;
                last_word <= data_lo;
            end
        end
    end
endmodule : rxfc_sink

/* File: bench/rxfc_top_tb.sv */
// Self-checking bench for the receive frame check block
`timescale 1ns/1ps
module rxfc_top_tb;
    import rxfc_pkg::*;
    logic         clk_sys, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic         rx_in_valid, rx_in_sop, rx_in_eop, rx_in_fcs_bad, se;
    logic [511:0] rx_in_data, rx_data_out;
    logic [5:0]   rx_in_mty, rx_mty_out, last_mty;
    logic         rx_beat_valid_out, rx_sop_out, rx_eop_out, rx_err_out;
    logic         stat_rx_good, stat_rx_bad_fcs, stat_rx_oversize;
    logic         stat_rx_undersize, stat_rx_runt, irq, clr, last_err;
    logic         pcs_valid, lane_locked;
    logic [63:0]  pcs_word;
    logic [4:0]   lane_id, flags;
    logic [7:0]   beats, sops;
    logic [31:0]  last_word;
    int           bad_count, total_checks;

    // ==========
    // Instances
    rxfc_top rxfc_top_i (.clk_sys, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .prdata, .pslverr, .rx_in_valid,
        .rx_in_data, .rx_in_sop, .rx_in_eop, .rx_in_mty, .rx_in_fcs_bad,
        .rx_beat_valid_out, .rx_data_out, .rx_sop_out, .rx_eop_out,
        .rx_err_out, .rx_mty_out, .stat_rx_good, .stat_rx_bad_fcs,
        .stat_rx_oversize, .stat_rx_undersize, .stat_rx_runt, .pcs_valid,
        .pcs_word, .lane_locked, .lane_id, .irq);
    rxfc_sink rxfc_sink_i (.clk_sys, .reset, .clr, .v(rx_beat_valid_out),
        .eop(rx_eop_out), .err(rx_err_out), .mty(rx_mty_out),
        .sop(rx_sop_out), .data_lo(rx_data_out[31:0]), .sops, .last_word,
        .st({stat_rx_good, stat_rx_bad_fcs, stat_rx_oversize,
             stat_rx_undersize, stat_rx_runt}),
        .last_err, .last_mty, .flags, .beats);

    // ==========
    // Tasks
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    // One APB transfer, request held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask : rdc

    // Packet of n beats, then end-beat fields and stat flags
    task pk(input int n, input logic [5:0] m, input logic f, input logic ee,
            input logic [5:0] em, input logic [4:0] ef, input logic [4:0] fm,
            input logic [7:0] eb);
        @(posedge clk_sys);
        clr <= 1'b1;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys);
            clr <= 1'b0;
            rx_in_valid <= 1'b1;
            rx_in_sop <= (i == 0);
            rx_in_eop <= (i == n - 1);
            rx_in_mty <= (i == n - 1) ? m : 6'h00;
            rx_in_fcs_bad <= f & (i == n - 1);
        end
        @(posedge clk_sys);
        rx_in_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("err", {31'h0, last_err}, {31'h0, ee});
        chk("mty", {26'h0, last_mty}, {26'h0, em});
        chk("flags", {27'h0, flags & fm}, {27'h0, ef});
        chk("beats", {24'h0, beats}, {24'h0, eb});
        chk("sops", {24'h0, sops}, (eb != 8'h00) ? 32'h1 : 32'h0);
        chk("data", last_word, (eb != 8'h00) ? 32'h5A3CF069 : 32'h0);
    endtask : pk

    task pw(input logic [63:0] w);
        @(posedge clk_sys);
        pcs_valid <= 1'b1;
        pcs_word <= w;
        @(posedge clk_sys);
        pcs_valid <= 1'b0;
    endtask : pw

    task summarize;
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize

    // ==========
    // Clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end

    // ==========
    // Tests
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, rx_in_valid, rx_in_sop} = '0;
        {rx_in_eop, rx_in_mty, rx_in_fcs_bad, pcs_valid, pcs_word, clr} = '0;
        rx_in_data = {8{64'hA5C3_0F96_5A3C_F069}};
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rdc(RXFC_ADDR_MAXLEN, 32'h2580, "maxlen");
        rdc(RXFC_ADDR_MINLEN, 32'h40, "minlen");
        rdc(RXFC_ADDR_SPACING, 32'h3FFF, "spacing");
        rdc(12'h100, 32'h3E97DE00, "lane0 lo");
        rdc(12'h104, 32'hC1682100, "lane0 hi");
        rdc(12'h19C, 32'hC0F0E500, "lane19 hi");
        apb(1'b0, 12'h020, 32'h0);
        chk("slverr", {31'h0, se}, 32'h1);
        apb(1'b1, RXFC_ADDR_MASK, 32'h1F);
        pk(2, 6'h04, 1'b1, 1'b1, 6'h04, 5'h08, 5'h1F, 8'h02);
        @(negedge clk_sys);
        chk("irq set", {31'h0, irq}, 32'h1);
        rdc(RXFC_ADDR_STATUS, 32'h01, "status");
        @(negedge clk_sys);
        chk("irq clr", {31'h0, irq}, 32'h0);
        apb(1'b1, RXFC_ADDR_CTRL, 32'h1);
        pk(2, 6'h04, 1'b1, 1'b0, 6'h04, 5'h18, 5'h1F, 8'h02);
        pk(1, 6'h01, 1'b0, 1'b0, 6'h00, 5'h01, 5'h1F, 8'h00);
        apb(1'b1, RXFC_ADDR_MINLEN, 32'h80);
        pk(1, 6'h00, 1'b0, 1'b1, 6'h00, 5'h02, 5'h1F, 8'h01);
        apb(1'b1, RXFC_ADDR_MINLEN, 32'h40);
        apb(1'b1, RXFC_ADDR_MAXLEN, 32'h64);
        pk(3, 6'h00, 1'b0, 1'b1, 6'h1C, 5'h04, 5'h0E, 8'h02);
        apb(1'b1, RXFC_ADDR_MASK, 32'h0);
        @(negedge clk_sys);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b0, RXFC_ADDR_STATUS, 32'h0);
        chk("status", rd & 32'h1E, 32'h0E);
        apb(1'b1, RXFC_ADDR_SPACING, 32'h2);
        apb(1'b1, 12'h138, 32'h89ABCDEF);
        apb(1'b1, 12'h13C, 32'h01234567);
        rdc(12'h13C, 32'h01234567, "lane7 hi");
        pw(64'h0123456789ABCDEF);
        repeat (3) pw(64'h0);
        pw(64'h0123456789ABCDEF);
        @(negedge clk_sys);
        chk("lock", {26'h0, lane_locked, lane_id}, 32'h27);
        rdc(RXFC_ADDR_LANE, 32'h27, "lane reg");
        repeat (4) pw(64'h0);
        @(negedge clk_sys);
        chk("unlock", {31'h0, lane_locked}, 32'h0);
        summarize();
    end
endmodule : rxfc_top_tb
